// ### rtl/csdb_top.v
// Channel-status staging and transmit buffers with host byte port
`timescale 1ns/100ps
`include "csdb_regs.vh"
module csdb_top (
  input wire clk_in,
  input wire reset_in,
  input wire host_req_in,
  input wire host_write_in,
  input wire [7:0] host_addr_in,
  input wire [7:0] host_wdata_in,
  output reg host_ready_out,
  output wire [7:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in,
  input wire [7:0] tx_control1_in,
  input wire [7:0] tx_control2_in,
  input wire cs_read_channel_b_in,
  input wire power_down_bit_in,
  input wire mclk_present_in,
  input wire status_read_in,
  input wire copy_done_mask_in,
  output reg block_copy_done_flag_out,
  input wire frame_tick_in,
  input wire [23:0] sample_a_in,
  input wire [23:0] sample_b_in,
  output reg [23:0] sub_a_out,
  output reg [23:0] sub_b_out,
  output reg cs_bit_a_out,
  output reg cs_bit_b_out,
  output reg block_start_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_READ_B = 2'b10;

  reg [15:0] e_buf [0:23];
  reg [15:0] f_buf [0:23];
  reg [1:0] state;
  reg [1:0] next_state;
  reg [4:0] pending_word;
  reg write_phase;
  reg [7:0] held_a_byte;
  reg [7:0] frame_index;
  reg mclk_meta;
  reg mclk_seen;
  reg push_valid;
  reg [7:0] push_data;
  integer i;
  wire [23:0] mux_a;
  wire [23:0] mux_b;
  wire [3:0] fifo_count;
  wire fifo_in_ready;
  wire access_two_byte;
  wire copy_inhibit;
  wire host_take;
  wire buf_hit;
  wire [4:0] word_idx;
  wire [15:0] hit_word;
  wire write_allowed;
  wire block_end;
  wire do_copy;
  wire done_event;

  // ============================================================
  // Address decode helpers
  function in_buffer;
    input [7:0] addr;
    begin
      in_buffer = (addr >= `CSDB_BUF_BASE) && (addr < (`CSDB_BUF_BASE + `CSDB_BUF_WORDS));
    end
  endfunction

  function [4:0] word_of;
    input [7:0] addr;
    reg [7:0] diff;
    begin
      diff = addr - `CSDB_BUF_BASE;
      word_of = diff[4:0];
    end
  endfunction

  // Serial order: bit 0 of a block is the MSB of the byte
  function cs_pick;
    input [15:0] word;
    input [2:0] bit_pos;
    input chan_b;
    begin
      cs_pick = word[{~chan_b, ~bit_pos}];
    end
  endfunction

  // ============================================================
  // Control field extraction
  assign access_two_byte = tx_control1_in[`CSDB_ACCESS_WIDTH_BIT];
  assign copy_inhibit = tx_control1_in[`CSDB_INHIBIT_BIT];
  assign host_take = host_req_in && host_ready_out;
  assign buf_hit = in_buffer(host_addr_in);
  assign word_idx = word_of(host_addr_in);
  assign hit_word = e_buf[word_idx];
  // Clock presence crosses in from outside, so it is synchronised first
  assign write_allowed = mclk_seen && !power_down_bit_in;

  // ============================================================
  // Master clock presence synchroniser
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      mclk_meta <= 1'b0;
      mclk_seen <= 1'b0;
    end
    else
    begin
      mclk_meta <= mclk_present_in;
      mclk_seen <= mclk_meta;
    end
  end

  // ============================================================
  // Read sequencing into the return FIFO
  always @*
  begin
    next_state = state;
    push_valid = 1'b0;
    push_data = `CSDB_UNMAPPED_READ;
    case (state)
      ST_IDLE:
      begin
        if (host_take && !host_write_in)
        begin
          push_valid = 1'b1;
          if (!buf_hit)
            push_data = `CSDB_UNMAPPED_READ;
          else if (access_two_byte)
          begin
            push_data = hit_word[15:8];
            next_state = ST_READ_B;
          end
          else if (cs_read_channel_b_in)
            push_data = hit_word[7:0];
          else
            push_data = hit_word[15:8];
        end
      end
      ST_READ_B:
      begin
        push_valid = 1'b1;
        push_data = e_buf[pending_word][7:0];
        next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Ready is registered with room left for a two-byte read in flight
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state <= ST_IDLE;
      pending_word <= 5'd0;
      host_ready_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (host_take)
        pending_word <= word_idx;
      host_ready_out <= (next_state == ST_IDLE) && fifo_in_ready
        && (fifo_count <= `CSDB_FIFO_ROOM);
    end
  end

  // ============================================================
  // Staging buffer writes and block copy
  assign block_end = frame_tick_in && (frame_index == `CSDB_LAST_FRAME);
  assign do_copy = block_end && !copy_inhibit;
  assign done_event = do_copy && copy_done_mask_in;

  // Host reaches only the staging words; transmit words load as a block
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      write_phase <= 1'b0;
      held_a_byte <= `CSDB_BYTE_RESET;
      for (i = 0; i < 24; i = i + 1)
      begin
        e_buf[i] <= `CSDB_WORD_RESET;
        f_buf[i] <= `CSDB_WORD_RESET;
      end
    end
    else
    begin
      if (!access_two_byte)
        write_phase <= 1'b0;
      if (host_take && host_write_in && buf_hit && write_allowed)
      begin
        if (!access_two_byte)
          e_buf[word_idx] <= {host_wdata_in, host_wdata_in};
        else if (!write_phase)
        begin
          held_a_byte <= host_wdata_in;
          write_phase <= 1'b1;
        end
        else
        begin
          e_buf[word_idx] <= {held_a_byte, host_wdata_in};
          write_phase <= 1'b0;
        end
      end
      // Whole-block copy in one edge: never a half-old block on the wire
      if (do_copy)
      begin
        for (i = 0; i < 24; i = i + 1)
          f_buf[i] <= e_buf[i];
      end
    end
  end

  // ============================================================
  // Sticky completion flag; set wins over clear, masking forces it low
  always @(posedge clk_in)
  begin
    if (reset_in)
      block_copy_done_flag_out <= 1'b0;
    else if (done_event)
      block_copy_done_flag_out <= 1'b1;
    else if (status_read_in || !copy_done_mask_in)
      block_copy_done_flag_out <= 1'b0;
  end

  // ============================================================
  // Output time base: frame counter and channel-status bits
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      frame_index <= 8'h00;
      block_start_out <= 1'b0;
      cs_bit_a_out <= 1'b0;
      cs_bit_b_out <= 1'b0;
    end
    else
    begin
      block_start_out <= block_end;
      if (block_end)
        frame_index <= 8'h00;
      else if (frame_tick_in)
        frame_index <= frame_index + 8'h01;
      // Transmit buffer is the only source of serial status bits
      cs_bit_a_out <= cs_pick(f_buf[frame_index[7:3]], frame_index[2:0], 1'b0);
      cs_bit_b_out <= cs_pick(f_buf[frame_index[7:3]], frame_index[2:0], 1'b1);
    end
  end

  // ============================================================
  // Mono steering, registered so outputs come from flops
  csdb_mono_mux u_mono (
    .mono_enable_in(tx_control2_in[`CSDB_MONO_EN_BIT]),
    .mono_channel_select_in(tx_control2_in[`CSDB_MONO_SEL_BIT]),
    .sample_a_in(sample_a_in),
    .sample_b_in(sample_b_in),
    .sub_a_out(mux_a),
    .sub_b_out(mux_b)
  );

  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sub_a_out <= 24'h000000;
      sub_b_out <= 24'h000000;
    end
    else
    begin
      sub_a_out <= mux_a;
      sub_b_out <= mux_b;
    end
  end

  // ============================================================
  // Read-return FIFO; a stalled reader throttles host_ready_out
  csdb_fifo #(
    .WIDTH(`CSDB_FIFO_WIDTH),
    .DEPTH(`CSDB_FIFO_DEPTH),
    .AW(`CSDB_FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .in_valid_in(push_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_data),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in),
    .out_data_out(rd_data_out),
    .count_out(fifo_count)
  );
endmodule // csdb_top

// ### pkg/csdb_regs.vh
// Constants for the channel-status double buffer
`ifndef CSDB_REGS_VH
`define CSDB_REGS_VH

// ============================================================
// Staging buffer address map
`define CSDB_BUF_BASE 8'h13
`define CSDB_BUF_WORDS 8'd24
`define CSDB_WORD_IDX_W 5

// ============================================================
// Control byte field positions
`define CSDB_MONO_SEL_BIT 0
`define CSDB_MONO_EN_BIT 2
`define CSDB_ACCESS_WIDTH_BIT 5
`define CSDB_INHIBIT_BIT 6

// ============================================================
// Block timing and reset values
`define CSDB_LAST_FRAME 8'hbf
`define CSDB_BYTE_RESET 8'h00
`define CSDB_WORD_RESET 16'h0000
`define CSDB_UNMAPPED_READ 8'h00

// ============================================================
// Read-return FIFO shape
`define CSDB_FIFO_WIDTH 8
`define CSDB_FIFO_DEPTH 8
`define CSDB_FIFO_AW 3
`define CSDB_FIFO_ROOM 4'd5

`endif

// ### rtl/csdb_fifo.v
// Read-return FIFO with a registered head stage
`timescale 1ns/100ps
module csdb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_in,
  input wire reset_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output reg out_valid_out,
  input wire out_ready_in,
  output reg [WIDTH-1:0] out_data_out,
  output reg [AW:0] count_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire push;
  wire pop;
  // ============================================================
  // Handshake terms
  assign in_ready_out = (count_out != DEPTH[AW:0]);
  assign push = in_valid_in && in_ready_out;
  // Head refills whenever it is empty or being taken
  assign pop = (count_out != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);

  // ============================================================
  // Storage and pointers
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count_out <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data_in;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count_out <= count_out + 1'b1;
      else if (pop && !push)
        count_out <= count_out - 1'b1;
    end
  end

  // ============================================================
  // Registered head keeps the output straight from flops
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      out_valid_out <= 1'b0;
      out_data_out <= {WIDTH{1'b0}};
    end
    else if (pop)
    begin
      out_valid_out <= 1'b1;
      out_data_out <= mem[rd_ptr];
    end
    else if (out_ready_in)
      out_valid_out <= 1'b0;
  end
endmodule // csdb_fifo

// ### rtl/csdb_mono_mux.v
// Subframe sample steering for stereo and mono operation
`timescale 1ns/100ps
module csdb_mono_mux (
  input wire mono_enable_in,
  input wire mono_channel_select_in,
  input wire [23:0] sample_a_in,
  input wire [23:0] sample_b_in,
  output wire [23:0] sub_a_out,
  output wire [23:0] sub_b_out
);
  wire [23:0] mono_sample;
  // ============================================================
  // Mono copies one input channel into both subframes
  assign mono_sample = mono_channel_select_in ? sample_b_in : sample_a_in;
  assign sub_a_out = mono_enable_in ? mono_sample : sample_a_in;
  assign sub_b_out = mono_enable_in ? mono_sample : sample_b_in;
endmodule // csdb_mono_mux

// ### verification/csdb_sva.sv
// Port checker for the channel-status double buffer
`timescale 1ns/100ps
// ==========================================
// Checker module
module csdb_sva (
  input wire clk_in,
  input wire reset_in,
  input wire host_req_in,
  input wire host_write_in,
  input wire [7:0] host_addr_in,
  input wire host_ready_out,
  input wire [7:0] tx_control1_in,
  input wire [7:0] tx_control2_in,
  input wire status_read_in,
  input wire copy_done_mask_in,
  input wire block_copy_done_flag_out,
  input wire frame_tick_in,
  input wire [23:0] sample_a_in,
  input wire [23:0] sample_b_in,
  input wire [23:0] sub_a_out,
  input wire [23:0] sub_b_out,
  input wire block_start_out
);
  reg [7:0] idx;
  wire last = frame_tick_in && idx == 8'hbf;
  wire copy = last && !tx_control1_in[6] && copy_done_mask_in;
  wire flag = block_copy_done_flag_out;
  wire rd2 = host_req_in && host_ready_out && !host_write_in && tx_control1_in[5];
  // Shadow frame index, so block ends are known without peeking inside
  always @(posedge clk_in)
  begin
    if (reset_in)
      idx <= 8'h00;
    else if (frame_tick_in)
      idx <= last ? 8'h00 : idx + 8'h01;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  mono_chan_a_a: assert property (
    tx_control2_in[2] && !tx_control2_in[0] |=> sub_a_out == $past(sample_a_in)
    && sub_b_out == $past(sample_a_in)) else $error("mono A steering wrong");
  mono_chan_b_a: assert property (
    tx_control2_in[2] && tx_control2_in[0] |=> sub_a_out == $past(sample_b_in)
    && sub_b_out == $past(sample_b_in)) else $error("mono B steering wrong");
  copy_sets_flag_a: assert property (copy |=> flag)
    else $error("flag not set by copy");
  inhibit_holds_a: assert property (last && tx_control1_in[6] && !flag |=> !flag)
    else $error("flag set while inhibited");
  flag_sticky_a: assert property (flag && !status_read_in && copy_done_mask_in |=> flag)
    else $error("flag lost without status read");
  flag_clear_a: assert property (status_read_in && !copy |=> !flag)
    else $error("flag kept after status read");
  flag_masked_a: assert property (!copy_done_mask_in |=> !flag)
    else $error("flag shown while masked");
  block_start_a: assert property (last |=> block_start_out ##1 !block_start_out)
    else $error("block start pulse wrong");
  two_byte_gap_a: assert property (
    rd2 && host_addr_in >= 8'h13 && host_addr_in <= 8'h2a |=> !host_ready_out)
    else $error("ready high after two-byte read");
  cover property (copy);
  cover property (rd2);
  cover property (tx_control2_in[2] && tx_control2_in[0]);
endmodule // csdb_sva

bind csdb_top csdb_sva u_sva (.clk_in, .reset_in, .host_req_in, .host_write_in,
  .host_addr_in, .host_ready_out, .tx_control1_in, .tx_control2_in, .status_read_in,
  .copy_done_mask_in, .block_copy_done_flag_out, .frame_tick_in, .sample_a_in,
  .sample_b_in, .sub_a_out, .sub_b_out, .block_start_out);

// ### verification/csdb_host_model.sv
// Host controller model driving the byte request port
`timescale 1ns/100ps
// ==========================================
// Request driver
module csdb_host_model (
  input wire clk_in,
  input wire host_ready_in,
  output reg req_out,
  output reg write_out,
  output reg [7:0] addr_out,
  output reg [7:0] wdata_out
);
  initial
  begin
    req_out = 1'b0;
    write_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // Holds one byte request until ready is seen; gives up after lim edges
  task acc(input w, input [7:0] a, input [7:0] d, input integer lim, output ok);
    integer k;
  begin
    ok = 1'b0;
    req_out = 1'b1;
    write_out = w;
    addr_out = a;
    wdata_out = d;
    for (k = 0; k < lim && !ok; k = k + 1)
    begin
      @(posedge clk_in);
      ok = host_ready_in;
    end
    #1;
    req_out = 1'b0;
    // Idle lines flip so a stale address never looks valid
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
    @(posedge clk_in);
    #1;
  end
  endtask
endmodule // csdb_host_model

// ### verification/csdb_top_test.sv
// Self-checking bench for the channel-status double buffer
`timescale 1ns/100ps
// ==========================================
// Bench top
module csdb_top_test;
  reg clk_in = 1'b0;
  reg reset_in = 1'b1;
  reg rd_ready_in = 1'b1;
  reg [7:0] tx_control1_in = 8'h00;
  reg [7:0] tx_control2_in = 8'h00;
  reg cs_read_channel_b_in = 1'b0;
  reg power_down_bit_in = 1'b0;
  reg mclk_present_in = 1'b1;
  reg status_read_in = 1'b0;
  reg copy_done_mask_in = 1'b1;
  reg frame_tick_in = 1'b0;
  reg [23:0] sample_a_in = 24'h123456;
  reg [23:0] sample_b_in = 24'hfedcba;
  wire host_req_in, host_write_in, host_ready_out, rd_valid_out, block_start_out;
  wire block_copy_done_flag_out, cs_bit_a_out, cs_bit_b_out;
  wire [7:0] host_addr_in, host_wdata_in, rd_data_out;
  wire [23:0] sub_a_out, sub_b_out;
  integer n_errors = 0;
  integer checks_done = 0;
  reg ok;
  always #10 clk_in = ~clk_in;
  csdb_host_model host (.clk_in, .host_ready_in(host_ready_out), .req_out(host_req_in),
    .write_out(host_write_in), .addr_out(host_addr_in), .wdata_out(host_wdata_in));
  csdb_top DUT (.clk_in, .reset_in, .host_req_in, .host_write_in, .host_addr_in,
    .host_wdata_in, .host_ready_out, .rd_data_out, .rd_valid_out, .rd_ready_in,
    .tx_control1_in, .tx_control2_in, .cs_read_channel_b_in, .power_down_bit_in,
    .mclk_present_in, .status_read_in, .copy_done_mask_in, .block_copy_done_flag_out,
    .frame_tick_in, .sample_a_in, .sample_b_in, .sub_a_out, .sub_b_out, .cs_bit_a_out,
    .cs_bit_b_out, .block_start_out);
  task test_done;
  begin
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // A wait that ran out ends the run at once
  task need(input c);
  begin
    chk(c, 1);
    if (c !== 1'b1)
      test_done;
  end
  endtask
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clk_in);
    #1;
  end
  endtask
  task req(input w, input [7:0] a, input [7:0] d);
  begin
    host.acc(w, a, d, 20, ok);
    need(ok);
  end
  endtask
  // Byte is taken at the edge where valid is seen with ready high
  task pop(input [7:0] exp);
    integer k;
  begin
    k = 0;
    @(posedge clk_in);
    while (rd_valid_out !== 1'b1 && k < 20)
    begin
      @(posedge clk_in);
      k = k + 1;
    end
    need(rd_valid_out);
    chk(rd_data_out, exp);
    #1;
  end
  endtask
  task tick(input integer n);
  begin
    repeat (n)
    begin
      frame_tick_in = 1'b1;
      cyc(1);
      frame_tick_in = 1'b0;
      cyc(1);
    end
  end
  endtask
  task cs(input ea, input eb, input ef);
  begin
    chk({cs_bit_a_out, cs_bit_b_out, block_copy_done_flag_out}, {ea, eb, ef});
  end
  endtask
  task mono(input [7:0] ctl, input [23:0] ea, input [23:0] eb);
  begin
    tx_control2_in = ctl;
    cyc(2);
    chk({sub_a_out, sub_b_out}, {ea, eb});
  end
  endtask
  task s_map;
  begin
    req(1, 8'h13, 8'ha7);
    tx_control1_in = 8'h20;
    req(0, 8'h13, 8'h00);
    pop(8'ha7);
    pop(8'ha7);
    req(1, 8'h2a, 8'h5a);
    req(1, 8'h2a, 8'hc3);
    req(0, 8'h2a, 8'h00);
    pop(8'h5a);
    pop(8'hc3);
    tx_control1_in = 8'h00;
    cs_read_channel_b_in = 1'b1;
    req(0, 8'h2a, 8'h00);
    pop(8'hc3);
    req(0, 8'h2b, 8'h00);
    pop(8'h00);
  end
  endtask
  // Writes while powered down or without master clock must be lost
  task s_gate;
  begin
    power_down_bit_in = 1'b1;
    req(1, 8'h14, 8'h3c);
    power_down_bit_in = 1'b0;
    mclk_present_in = 1'b0;
    cyc(3);
    req(1, 8'h14, 8'h3c);
    mclk_present_in = 1'b1;
    cyc(3);
    req(0, 8'h14, 8'h00);
    pop(8'h00);
  end
  endtask
  // Read with the reader stalled until host_ready_out stays low, then drain the FIFO empty
  task s_fill;
    integer n;
  begin
    n = 0;
    ok = 1'b1;
    rd_ready_in = 1'b0;
    while (ok && n < 12)
    begin
      host.acc(0, 8'h13, 8'h00, 3, ok);
      if (ok)
        n = n + 1;
    end
    chk(ok, 0);
    rd_ready_in = 1'b1;
    repeat (n) pop(8'ha7);
    cyc(3);
    chk(rd_valid_out, 0);
  end
  endtask
  // Host writes only after a copy and keeps long sessions inhibited
  task s_block;
  begin
    tick(192);
    cs(1, 1, 1);
    status_read_in = 1'b1;
    cyc(1);
    status_read_in = 1'b0;
    chk(block_copy_done_flag_out, 0);
    tx_control1_in = 8'h60;
    // Read-modify-write: fetch both halves before changing them
    req(0, 8'h13, 8'h00);
    pop(8'ha7);
    pop(8'ha7);
    req(1, 8'h13, 8'h01);
    req(1, 8'h13, 8'h80);
    tick(192);
    cs(1, 1, 0);
    tx_control1_in = 8'h20;
    copy_done_mask_in = 1'b0;
    tick(192);
    cs(0, 1, 0);
    tick(7);
    cs(1, 0, 0);
    copy_done_mask_in = 1'b1;
    tick(185);
    chk(block_copy_done_flag_out, 1);
    // A masked source must read 0 even when it was already set
    copy_done_mask_in = 1'b0;
    cyc(1);
    chk(block_copy_done_flag_out, 0);
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk_in);
    #1;
    chk({host_ready_out, rd_valid_out, block_copy_done_flag_out}, 0);
    reset_in = 1'b0;
    cyc(4);
    mono(8'h04, 24'h123456, 24'h123456);
    mono(8'h05, 24'hfedcba, 24'hfedcba);
    mono(8'h00, 24'h123456, 24'hfedcba);
    s_map;
    s_gate;
    s_fill;
    s_block;
    test_done;
  end
endmodule // csdb_top_test
